// *** pci_edge.sv ***
// One port's edge detectors and sticky flags
module pci_edge
  import pci_pkg::*;
#(
  parameter int W = PCI_PORT_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Synchronised pin levels and pin availability
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] avail,
  // Enables
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  // Flag write from software
  input  wire logic         flag_we,
  input  wire logic [W-1:0] flag_wdata,
  // Flags
  output logic      [W-1:0] flags
);
  logic [W-1:0] prev;
  logic [W-1:0] hit;
  logic [W-1:0] next_flags;

  // Edge = current synchronised sample differs from last clock's
  always_comb begin
    // [RL4]
    hit = ((pins & ~prev & rise_en) | (~pins & prev & fall_en)) & avail; // [RL1]
    next_flags = flags;
    if (flag_we) begin
      next_flags = flags & flag_wdata; // [RL9]
    end
    next_flags = next_flags | hit; // [RL10]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev  <= PCI_RST_BYTE;
      flags <= PCI_RST_BYTE;
    end else begin
      prev  <= pins; // [RL16]
      flags <= next_flags; // [RL6]
    end
  end
endmodule // pci_edge

// *** pci_pin_model.sv ***
// Far-side model: external pin levels of ports A, B, C and E
module pci_pins
  import pci_pkg::*;
#(
  parameter int W = PCI_PORT_W
) (
  // Clock
  input  wire logic           clk,
  // Pin levels, port A in the low byte
  output logic      [4*W-1:0] p
);
  initial p = '0;
  // Levels hold until the next call, well over the two-cycle minimum
  task automatic put(input int n, input logic [W-1:0] v);
    @(posedge clk);
    p[n*W +: W] <= v;
  endtask
endmodule // pci_pins

// *** pci_pkg.sv ***
// Package: register map, layout and reset values for the pin change block
package pci_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int PCI_PORT_W  = 8;
  localparam int PCI_PORTS   = 4;
  localparam int PCI_ADDR_W  = 16;
  localparam int PCI_DATA_W  = 8;
  // Ports A, B, C, E; port E only has pin 3 wired
  localparam logic [PCI_PORT_W-1:0] PCI_PORT_A_MASK = 8'hFF;
  localparam logic [PCI_PORT_W-1:0] PCI_PORT_B_MASK = 8'hFF;
  localparam logic [PCI_PORT_W-1:0] PCI_PORT_C_MASK = 8'hFF;
  localparam logic [PCI_PORT_W-1:0] PCI_PORT_E_MASK = 8'h08;
  // Master-clear pin sits on port E, pin 3
  localparam int PCI_MASTER_CLEAR_PORT = 3;
  localparam int PCI_MASTER_CLEAR_BIT  = 3;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [PCI_ADDR_W-1:0] PCI_A_RISE = 16'h1F3D;
  localparam logic [PCI_ADDR_W-1:0] PCI_A_FALL = 16'h1F3E;
  localparam logic [PCI_ADDR_W-1:0] PCI_A_FLAG = 16'h1F3F;
  localparam logic [PCI_ADDR_W-1:0] PCI_B_RISE = 16'h1F48;
  localparam logic [PCI_ADDR_W-1:0] PCI_B_FALL = 16'h1F49;
  localparam logic [PCI_ADDR_W-1:0] PCI_B_FLAG = 16'h1F4A;
  localparam logic [PCI_ADDR_W-1:0] PCI_C_RISE = 16'h1F53;
  localparam logic [PCI_ADDR_W-1:0] PCI_C_FALL = 16'h1F54;
  localparam logic [PCI_ADDR_W-1:0] PCI_C_FLAG = 16'h1F55;
  localparam logic [PCI_ADDR_W-1:0] PCI_E_RISE = 16'h1F69;
  localparam logic [PCI_ADDR_W-1:0] PCI_E_FALL = 16'h1F6A;
  localparam logic [PCI_ADDR_W-1:0] PCI_E_FLAG = 16'h1F6B;
  // Own control/status register
  localparam logic [PCI_ADDR_W-1:0] PCI_CTRL   = 16'h1F70;
  localparam int PCI_CTRL_MEN_BIT  = 0;
  localparam int PCI_CTRL_REQ_BIT  = 1;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [PCI_PORT_W-1:0] PCI_RST_BYTE = 8'h00;
  localparam logic [PCI_DATA_W-1:0] PCI_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    PCI_FLD_RISE = 2'b00,
    PCI_FLD_FALL = 2'b01,
    PCI_FLD_FLAG = 2'b10,
    PCI_FLD_NONE = 2'b11
  } pci_field_t;
endpackage : pci_pkg

// *** pci_sync.sv ***
// Two-stage synchroniser for a bus of pin levels
module pci_sync
  import pci_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2;
endmodule // pci_sync

// *** pci_top.sv ***
// Top of the pin change interrupt block: registers, detectors, request
//
// What this block does
// [RL1] Each change-capable pin has its own rising and falling detector.
// [RL2] A set rising enable bit arms rising detection; clear disarms it.
// [RL3] A set falling enable bit arms falling detection; clear disarms it.
// [RL4] With both enables set, edges of either polarity are caught.
// [RL5] Any pin or combination of pins may contribute independently.
// [RL6] An enabled edge sets that pin's flag at the pin's bit position.
// [RL7] Detection and flagging go on while the master enable is clear.
// [RL8] The summary request is the read-only OR of every flag bit.
// [RL9] Writing zero to a flag bit clears it; writing one leaves it.
// [RL10] An edge during a flag write leaves that flag set.
// [RL11] Software should clear flags by AND-masking only seen bits.
// [RL12] A change event wakes the core when the master enable is set.
// [RL13] Edges in sleep are flagged before the core's first instruction.
// [RL14] With reset-pin or low-voltage-prog enable set, master clear
//        never sets a flag.
// [RL15] Enable and flag registers are 8-bit read/write, reset to zero.
// [RL16] Edges are found by comparing synchronised samples clock to clock.
//
// Local design decisions: the register addresses and the address-and-strobe port.
module pci_top
  import pci_pkg::*;
#(
  parameter int W = PCI_PORT_W
) (
  // Clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  SYS_RST,
  // Register port
  input  wire logic [PCI_ADDR_W-1:0] REG_ADDR,
  input  wire logic [PCI_DATA_W-1:0] REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [PCI_DATA_W-1:0] REG_RDATA,
  // Pins
  input  wire logic [W-1:0]          PORT_A_PINS,
  input  wire logic [W-1:0]          PORT_B_PINS,
  input  wire logic [W-1:0]          PORT_C_PINS,
  input  wire logic [W-1:0]          PORT_E_PINS,
  // Configuration bits
  input  wire logic                  EXT_RESET_PIN_ENABLE,
  input  wire logic                  LOW_VOLTAGE_PROG_ENABLE,
  // Core side
  output logic                       CHANGE_INT_SUMMARY_REQUEST,
  output logic                       CHANGE_INT_REQ,
  output logic                       WAKE_REQ
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [W-1:0] rise_en      [PCI_PORTS];
  logic [W-1:0] fall_en      [PCI_PORTS];
  logic [W-1:0] next_rise_en [PCI_PORTS];
  logic [W-1:0] next_fall_en [PCI_PORTS];
  logic [W-1:0] flags        [PCI_PORTS];
  logic [W-1:0] pins_raw     [PCI_PORTS];
  logic [W-1:0] pins_sync    [PCI_PORTS];
  logic [W-1:0] avail        [PCI_PORTS];
  logic [PCI_PORTS-1:0] flag_we;
  logic         master_en;
  logic         next_master_en;
  logic [PCI_DATA_W-1:0] next_rdata;
  logic         next_summary;
  logic         cfg_mc_masked;
  logic         next_cfg_mc_masked;

  // Address to port index and field
  function automatic pci_field_t dec_field(input logic [PCI_ADDR_W-1:0] a);
    unique case (a)
      PCI_A_RISE, PCI_B_RISE, PCI_C_RISE, PCI_E_RISE: dec_field = PCI_FLD_RISE;
      PCI_A_FALL, PCI_B_FALL, PCI_C_FALL, PCI_E_FALL: dec_field = PCI_FLD_FALL;
      PCI_A_FLAG, PCI_B_FLAG, PCI_C_FLAG, PCI_E_FLAG: dec_field = PCI_FLD_FLAG;
      default: dec_field = PCI_FLD_NONE;
    endcase
  endfunction

  function automatic logic [1:0] dec_port(input logic [PCI_ADDR_W-1:0] a);
    unique case (a)
      PCI_A_RISE, PCI_A_FALL, PCI_A_FLAG: dec_port = 2'h0;
      PCI_B_RISE, PCI_B_FALL, PCI_B_FLAG: dec_port = 2'h1;
      PCI_C_RISE, PCI_C_FALL, PCI_C_FLAG: dec_port = 2'h2;
      default:                            dec_port = 2'h3;
    endcase
  endfunction

  assign pins_raw[0] = PORT_A_PINS;
  assign pins_raw[1] = PORT_B_PINS;
  assign pins_raw[2] = PORT_C_PINS;
  assign pins_raw[3] = PORT_E_PINS;

  // ---------------------------------------------------------------
  // Pin availability
  // ---------------------------------------------------------------
  // Config bits are static straps; registered once to keep them off
  // the async path and tolerate slow settling after reset.
  assign next_cfg_mc_masked = EXT_RESET_PIN_ENABLE | LOW_VOLTAGE_PROG_ENABLE;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_mc_masked <= 1'b1;
    end else begin
      cfg_mc_masked <= next_cfg_mc_masked;
    end
  end

  always_comb begin
    avail[0] = PCI_PORT_A_MASK;
    avail[1] = PCI_PORT_B_MASK;
    avail[2] = PCI_PORT_C_MASK;
    avail[3] = PCI_PORT_E_MASK;
    if (cfg_mc_masked) begin
      avail[PCI_MASTER_CLEAR_PORT][PCI_MASTER_CLEAR_BIT] = 1'b0; // [RL14]
    end
  end

  // ---------------------------------------------------------------
  // Per-port detectors
  // ---------------------------------------------------------------
  // Detectors run with no dependence on master enable or sleep, so an
  // edge in sleep is already in the flags when the core wakes.
  // [RL13]
  for (genvar p = 0; p < PCI_PORTS; p++) begin : g_port
    pci_sync #(
      .W (W)
    ) u_sync (
      .clk  (CORE_CLK),
      .rst  (SYS_RST),
      .din  (pins_raw[p]),
      .dout (pins_sync[p])
    );

    pci_edge #(
      .W (W)
    ) u_edge (
      .clk        (CORE_CLK),
      .rst        (SYS_RST),
      .pins       (pins_sync[p]),
      .avail      (avail[p]),
      .rise_en    (rise_en[p]), // [RL2]
      .fall_en    (fall_en[p]), // [RL3]
      .flag_we    (flag_we[p]),
      .flag_wdata (REG_WDATA[W-1:0]),
      .flags      (flags[p]) // [RL5]
    );
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_comb begin
    pci_field_t f;
    logic [1:0] ix;
    f  = dec_field(REG_ADDR);
    ix = dec_port(REG_ADDR);
    next_master_en = master_en;
    flag_we = '0;
    for (int p = 0; p < PCI_PORTS; p++) begin
      next_rise_en[p] = rise_en[p];
      next_fall_en[p] = fall_en[p];
    end
    if (REG_WR) begin
      unique case (f)
        PCI_FLD_RISE: next_rise_en[ix] = REG_WDATA[W-1:0] & avail[ix];
        PCI_FLD_FALL: next_fall_en[ix] = REG_WDATA[W-1:0] & avail[ix];
        PCI_FLD_FLAG: flag_we[ix] = 1'b1;
        PCI_FLD_NONE: begin
          if (REG_ADDR == PCI_CTRL) begin
            next_master_en = REG_WDATA[PCI_CTRL_MEN_BIT];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int p = 0; p < PCI_PORTS; p++) begin
        rise_en[p] <= PCI_RST_BYTE; // [RL15]
        fall_en[p] <= PCI_RST_BYTE;
      end
      master_en <= 1'b0;
    end else begin
      for (int p = 0; p < PCI_PORTS; p++) begin
        rise_en[p] <= next_rise_en[p];
        fall_en[p] <= next_fall_en[p];
      end
      master_en <= next_master_en;
    end
  end

  // ---------------------------------------------------------------
  // Read data and request outputs
  // ---------------------------------------------------------------
  always_comb begin
    pci_field_t f;
    logic [1:0] ix;
    f  = dec_field(REG_ADDR);
    ix = dec_port(REG_ADDR);
    next_summary = 1'b0;
    for (int p = 0; p < PCI_PORTS; p++) begin
      next_summary = next_summary | (|flags[p]); // [RL8]
    end
    next_rdata = PCI_UNMAPPED;
    if (REG_RD) begin
      unique case (f)
        PCI_FLD_RISE: next_rdata = rise_en[ix];
        PCI_FLD_FALL: next_rdata = fall_en[ix];
        PCI_FLD_FLAG: next_rdata = flags[ix];
        PCI_FLD_NONE: begin
          if (REG_ADDR == PCI_CTRL) begin
            next_rdata[PCI_CTRL_MEN_BIT] = master_en;
            next_rdata[PCI_CTRL_REQ_BIT] = next_summary;
          end
        end
      endcase
    end
  end

  // Summary follows flags one clock later; request is gated only here
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA                  <= PCI_UNMAPPED;
      CHANGE_INT_SUMMARY_REQUEST <= 1'b0;
      CHANGE_INT_REQ             <= 1'b0;
      WAKE_REQ                   <= 1'b0;
    end else begin
      REG_RDATA                  <= next_rdata;
      CHANGE_INT_SUMMARY_REQUEST <= next_summary; // [RL8]
      CHANGE_INT_REQ             <= next_summary & master_en; // [RL7]
      WAKE_REQ                   <= next_summary & master_en; // [RL12]
    end
  end
endmodule // pci_top

// *** pci_top_monitor.sv ***
// Port checker for the pin change block, bound to its top
module pci_chk
  import pci_pkg::*;
#(
  parameter int W = PCI_PORT_W
) (
  // Clock and reset
  input wire logic                  CORE_CLK,
  input wire logic                  SYS_RST,
  // Register port
  input wire logic [PCI_ADDR_W-1:0] REG_ADDR,
  input wire logic                  REG_WR,
  input wire logic                  REG_RD,
  input wire logic [PCI_DATA_W-1:0] REG_RDATA,
  // Pins
  input wire logic [W-1:0]          PORT_A_PINS,
  input wire logic [W-1:0]          PORT_B_PINS,
  input wire logic [W-1:0]          PORT_C_PINS,
  input wire logic [W-1:0]          PORT_E_PINS,
  // Core side
  input wire logic                  CHANGE_INT_SUMMARY_REQUEST,
  input wire logic                  CHANGE_INT_REQ,
  input wire logic                  WAKE_REQ
);
  logic         sum;
  logic         mapped;
  logic [4*W-1:0] pins;
  assign sum = CHANGE_INT_SUMMARY_REQUEST;
  assign pins = {PORT_A_PINS, PORT_B_PINS, PORT_C_PINS, PORT_E_PINS};
  assign mapped = REG_ADDR inside {PCI_A_RISE, PCI_A_FALL, PCI_A_FLAG,
    PCI_B_RISE, PCI_B_FALL, PCI_B_FLAG, PCI_C_RISE, PCI_C_FALL, PCI_C_FLAG,
    PCI_E_RISE, PCI_E_FALL, PCI_E_FLAG, PCI_CTRL};
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  a_wake_tracks_req: assert property (WAKE_REQ == CHANGE_INT_REQ)
    else $error("wake differs from interrupt request");
  a_req_needs_sum: assert property (CHANGE_INT_REQ |-> sum)
    else $error("interrupt request without summary");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read answer cycle");
  a_unmapped_zero: assert property (REG_RD && !mapped |=>
    REG_RDATA == PCI_UNMAPPED) else $error("unmapped read not zero");
  a_e_flag_bits: assert property (REG_RD && REG_ADDR == PCI_E_FLAG |=>
    (REG_RDATA & ~PCI_PORT_E_MASK) == 8'h00)
    else $error("absent port E flag bit set");
  a_sum_from_pin: assert property ($rose(sum) |->
    $past(pins, 4) != $past(pins, 5))
    else $error("summary rose without pin change five cycles before");
  a_sum_holds: assert property (sum && !REG_WR && !$past(REG_WR) |=> sum)
    else $error("summary dropped without flag write");
  a_sum_fall_write: assert property ($fell(sum) |-> $past(REG_WR, 2))
    else $error("summary fell without a write two cycles before");
endmodule // pci_chk

bind pci_top pci_chk #(.W(W)) u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PORT_A_PINS(PORT_A_PINS),
  .PORT_B_PINS(PORT_B_PINS), .PORT_C_PINS(PORT_C_PINS),
  .PORT_E_PINS(PORT_E_PINS),
  .CHANGE_INT_SUMMARY_REQUEST(CHANGE_INT_SUMMARY_REQUEST),
  .CHANGE_INT_REQ(CHANGE_INT_REQ), .WAKE_REQ(WAKE_REQ));

// *** tb_top.sv ***
// Self-checking bench for the pin change block
module tb_top
  import pci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        ext = 1'b0, low_voltage_prog_enable = 1'b0, sum, req, wake;
  logic [15:0] addr = '0;
  logic [7:0]  wd = '0, rdata, d;
  logic [31:0] pv;
  int          bad_count = 0, tests_run = 0;
  localparam logic [15:0] MAP [13] = '{PCI_A_RISE, PCI_A_FALL, PCI_A_FLAG,
    PCI_B_RISE, PCI_B_FALL, PCI_B_FLAG, PCI_C_RISE, PCI_C_FALL, PCI_C_FLAG,
    PCI_E_RISE, PCI_E_FALL, PCI_E_FLAG, PCI_CTRL};
  always #25 clk = ~clk;
  pci_pins pins (.clk(clk), .p(pv));
  pci_top uut (.CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PORT_A_PINS(pv[7:0]), .PORT_B_PINS(pv[15:8]), .PORT_C_PINS(pv[23:16]),
    .PORT_E_PINS(pv[31:24]), .EXT_RESET_PIN_ENABLE(ext),
    .LOW_VOLTAGE_PROG_ENABLE(low_voltage_prog_enable), .CHANGE_INT_SUMMARY_REQUEST(sum),
    .CHANGE_INT_REQ(req), .WAKE_REQ(wake));
  task automatic chk(input string n, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd8(a, v);
    chk(n, v, e);
  endtask
  // Five edges: two sync stages, detector, the summary register, then one spare
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_regs;
    logic [7:0] e;
    for (int i = 0; i < 13; i++) rchk("reset value", MAP[i], 8'h00);
    for (int i = 0; i < 12; i++) begin
      e = (i % 3 == 2) ? 8'h00 : (i > 8) ? 8'h08 : 8'hFF;
      wr8(MAP[i], 8'hFF);
      rchk("write back", MAP[i], e);
      wr8(MAP[i], 8'h00);
    end
    wr8(16'h1F40, 8'hFF);
    rchk("unmapped", 16'h1F40, PCI_UNMAPPED);
    $display("test regs done");
  endtask
  task automatic t_edges;
    wr8(PCI_A_RISE, 8'h05);
    wr8(PCI_A_FALL, 8'h06);
    wr8(PCI_B_RISE, 8'h80);
    wr8(PCI_C_FALL, 8'h01);
    pins.put(0, 8'h07);
    pins.put(1, 8'h80);
    settle;
    rchk("a rising", PCI_A_FLAG, 8'h05);
    rchk("b rising", PCI_B_FLAG, 8'h80);
    chk("request gated", {6'h00, req, sum}, 8'h01);
    wr8(PCI_A_FLAG, 8'h00);
    pins.put(0, 8'h00);
    pins.put(2, 8'h01);
    settle;
    rchk("a falling", PCI_A_FLAG, 8'h06);
    rchk("c rise unarmed", PCI_C_FLAG, 8'h00);
    pins.put(2, 8'h00);
    wr8(PCI_CTRL, 8'h01);
    settle;
    chk("wake", {6'h00, wake, req}, 8'h03);
    rchk("control", PCI_CTRL, 8'h03);
    wr8(PCI_B_FLAG, 8'h7F);
    wr8(PCI_C_FLAG, 8'hFF);
    rchk("ones keep", PCI_C_FLAG, 8'h01);
    rchk("zero clears", PCI_B_FLAG, 8'h00);
    wr8(PCI_A_FLAG, 8'h00);
    settle;
    chk("summary held", {7'h00, sum}, 8'h01);
    rd8(PCI_C_FLAG, d);
    wr8(PCI_C_FLAG, ~d);
    settle;
    chk("summary clear", {6'h00, sum, req}, 8'h00);
    $display("test edges done");
  endtask
  task automatic t_race;
    pins.put(0, 8'h01);
    @(posedge clk);
    wr8(PCI_A_FLAG, 8'h00);
    settle;
    rchk("set wins", PCI_A_FLAG, 8'h01);
    wr8(PCI_A_FLAG, 8'h00);
    $display("test race done");
  endtask
  task automatic t_mask;
    for (int i = 0; i < 2; i++) begin
      ext <= (i == 0);
      low_voltage_prog_enable <= (i == 1);
      do_reset;
      wr8(PCI_E_FALL, 8'hFF);
      wr8(PCI_E_RISE, 8'hFF);
      rchk("masked enable", PCI_E_RISE, 8'h00);
      pins.put(3, pv[31:24] ^ 8'h08);
      settle;
      rchk("masked flag", PCI_E_FLAG, 8'h00);
    end
    ext <= 1'b0;
    low_voltage_prog_enable <= 1'b0;
    do_reset;
    wr8(PCI_E_FALL, 8'h08);
    wr8(PCI_E_RISE, 8'h08);
    pins.put(3, pv[31:24] ^ 8'h08);
    settle;
    rchk("port e flag", PCI_E_FLAG, 8'h08);
    $display("test mask done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_edges;
    t_race;
    t_mask;
    print_verdict;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
endmodule // tb_top
